// [rtl/charger_path_pkg.sv]
// constants, field layouts and state codes for the battery path control
// assumes a 250 MHz system clock and synchronised comparator levels
`default_nettype none
package charger_path_pkg;
	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// register offsets
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] CURRENT_ADDR = 4'h1;
	localparam logic [ADDR_W-1:0] FAULT_ADDR = 4'h2;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
	// control field positions
	localparam int CTRL_THERM_BIT = 0;
	localparam int CTRL_JEITA_EN_BIT = 1;
	localparam int CTRL_JEITA_SEL_BIT = 2;
	// fault field positions
	localparam int FAULT_SHORT_BIT = 0;
	// status field positions
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ISO_LSB = 3;
	localparam int STAT_ZONE_LSB = 5;
	localparam int STAT_THERM_BIT = 8;
	// reset values
	localparam logic [4:0] CURRENT_RESET = 5'h0_7;
	localparam logic THERM_EN_RESET = 1'b0;
	// comparator vector layout
	localparam int CMP_SUPPLY_OK = 0;
	localparam int CMP_SUPPLY_RANGE = 1;
	localparam int CMP_BAT_DEAD = 2;
	localparam int CMP_BAT_SYS = 3;
	localparam int CMP_SYS_LOW = 4;
	localparam int CMP_BAT_LOW = 5;
	localparam int CMP_BAT_HIGH = 6;
	localparam int CMP_BAT_SHORT = 7;
	localparam int CMP_BAT_CUTOFF = 8;
	localparam int CMP_COLD = 9;
	localparam int CMP_COOL = 10;
	localparam int CMP_WARM = 11;
	localparam int CMP_HOT = 12;
	localparam int CMP_W = 13;
	// timing
	localparam int CNT_W = 40;
	localparam longint CLK_HZ = 64'h0000_0000_0EE6_B280;
	localparam longint THERM_INTERVAL_MS = 167;
	localparam longint TRICKLE_TIMEOUT_MIN = 60;
	localparam longint THERM_INTERVAL_CYCLES =
		THERM_INTERVAL_MS * CLK_HZ / 1000;
	localparam longint TRICKLE_TIMEOUT_CYCLES =
		TRICKLE_TIMEOUT_MIN * 60 * CLK_HZ;
	// charger state codes, fault is 110
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SINK = 3'b001,
		ST_SOURCE = 3'b010,
		ST_NO_BAT = 3'b011,
		ST_TRICKLE = 3'b100,
		ST_FAST = 3'b101,
		ST_FAULT = 3'b110
	} charger_state_type;
	// isolation switch modes
	typedef enum logic [1:0] {
		ISO_OFF = 2'b00,
		ISO_REGULATE = 2'b01,
		ISO_FULL = 2'b10
	} iso_mode_type;
	// battery temperature zones
	typedef enum logic [2:0] {
		ZONE_COLD = 3'b000,
		ZONE_COOL = 3'b001,
		ZONE_TYP = 3'b010,
		ZONE_WARM = 3'b011,
		ZONE_HOT = 3'b100
	} zone_type;
endpackage : charger_path_pkg
`default_nettype wire

// [rtl/level_sync.sv]
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow comparator level, not a multi-bit word
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg; // first stage, read only by second

	// two stage capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : level_sync
`default_nettype wire

// [rtl/cool_current_map.sv]
// cool zone charge current reduction map
// assumes 5-bit current codes in 50 mA steps from 50 mA, top two
// codes being 1200 mA and 1300 mA
`default_nettype none
module cool_current_map (
	// codes
	input wire logic [4:0] code_in,
	output logic [4:0] code_out
);
	// half current, floored to 50 mA, never under 50 mA
	always_comb begin
		if (code_in <= 5'h0_2) begin
			code_out = 5'h0_0;
		end else if (code_in <= 5'h1_5) begin
			code_out = 5'((code_in + 5'h0_1) >> 1) - 5'h0_1;
		end else if (code_in == 5'h1_6) begin
			code_out = 5'h0_B;
		end else begin
			code_out = 5'h0_C;
		end
	end
endmodule : cool_current_map
`default_nettype wire

// [rtl/charger_path_ctrl.sv]
// battery path control: detection, short check, isolation switch,
// thermistor gating and temperature zone charge adjustment
// assumes comparator levels from the analog front end, register
// port driven from the same clock
//
// Implementation choices: the register addresses and the strobed register port.
`default_nettype none
module charger_path_ctrl
	import charger_path_pkg::*;
#(
	parameter logic [CNT_W-1:0] DETECT_CYCLES = 40'h00_0003_D090,
	parameter logic [CNT_W-1:0] SHORT_CYCLES = 40'h00_0003_D090,
	parameter logic [CNT_W-1:0] TRICKLE_CYCLES =
		CNT_W'(TRICKLE_TIMEOUT_CYCLES),
	parameter logic [CNT_W-1:0] THERM_CYCLES =
		CNT_W'(THERM_INTERVAL_CYCLES),
	parameter logic [CNT_W-1:0] THERM_ON_CYCLES = 40'h00_0000_0100,
	parameter logic JEITA_EN_RESET = 1'b0,
	parameter logic JEITA_SEL_RESET = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// supply comparators
	input wire logic supply_input_ok,
	input wire logic supply_input_in_range,
	// battery and system node comparators
	input wire logic battery_above_dead,
	input wire logic battery_above_system_level,
	input wire logic system_node_below_battery,
	input wire logic battery_above_detect_low,
	input wire logic battery_above_detect_high,
	input wire logic battery_above_short,
	input wire logic battery_above_cutoff,
	// thermistor comparators
	input wire logic thermistor_cold,
	input wire logic thermistor_cool,
	input wire logic thermistor_warm,
	input wire logic thermistor_hot,
	// analog controls
	output logic [1:0] iso_mode,
	output logic sink_current_on,
	output logic source_current_on,
	output logic trickle_charge_on,
	output logic fast_charge_on,
	output logic [4:0] charge_current_code,
	output logic termination_drop,
	output logic thermistor_source_on
);
	////////////////////////////////////////////////////////////////////
	// comparator synchronisation
	logic [CMP_W-1:0] cmp_raw; // pin levels
	logic [CMP_W-1:0] cmp; // synchronised levels

	assign cmp_raw = {thermistor_hot, thermistor_warm, thermistor_cool,
		thermistor_cold, battery_above_cutoff, battery_above_short,
		battery_above_detect_high, battery_above_detect_low,
		system_node_below_battery, battery_above_system_level,
		battery_above_dead, supply_input_in_range, supply_input_ok};

	// every comparator passes two flops
	level_sync #(.WIDTH(CMP_W)) cmp_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in(cmp_raw),
		.sync_out(cmp)
	);

	////////////////////////////////////////////////////////////////////
	// registers
	logic therm_en_reg; // thermistor_sense_enable
	logic jeita_en_reg; // zone function enable
	logic jeita_sel_reg; // 0 first profile, 1 second
	logic [4:0] current_reg; // fast_charge_current_code
	logic short_fault_reg; // sticky short fault
	charger_state_type state_reg; // charger state
	charger_state_type state_next;
	zone_type zone; // decoded zone
	logic therm_active; // sensing allowed
	logic temp_stop; // cold or hot

	logic wr_ctrl; // control write
	logic wr_fault; // fault write
	assign wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
	assign wr_fault = reg_wr && (reg_addr == FAULT_ADDR);

	// control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			therm_en_reg <= THERM_EN_RESET;
			jeita_en_reg <= JEITA_EN_RESET;
			jeita_sel_reg <= JEITA_SEL_RESET;
		end else if (wr_ctrl) begin
			therm_en_reg <= reg_wdata[CTRL_THERM_BIT];
			jeita_en_reg <= reg_wdata[CTRL_JEITA_EN_BIT];
			jeita_sel_reg <= reg_wdata[CTRL_JEITA_SEL_BIT];
		end
	end

	// programmed charge current
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_reg <= CURRENT_RESET;
		end else if (reg_wr && (reg_addr == CURRENT_ADDR)) begin
			current_reg <= reg_wdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// timers
	logic [CNT_W-1:0] phase_cnt_reg; // detection period
	logic [CNT_W-1:0] short_cnt_reg; // short timeout
	logic [CNT_W-1:0] trk_cnt_reg; // trickle timeout
	logic phase_done; // detection period over
	logic short_done; // short timeout over
	logic trk_done; // trickle timeout over
	logic state_change; // state leaves this cycle

	assign state_change = (state_next != state_reg);
	assign phase_done = (phase_cnt_reg == DETECT_CYCLES - 1'b1);
	assign short_done = (short_cnt_reg == SHORT_CYCLES - 1'b1);
	assign trk_done = (trk_cnt_reg == TRICKLE_CYCLES - 1'b1);

	// detection phase counter, restarts per state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_cnt_reg <= '0;
		end else if (state_change || phase_done) begin
			phase_cnt_reg <= '0;
		end else begin
			phase_cnt_reg <= phase_cnt_reg + 1'b1;
		end
	end

	// short timeout counts from start of trickle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			short_cnt_reg <= '0;
		end else if (state_reg != ST_TRICKLE) begin
			short_cnt_reg <= '0;
		end else if (!short_done) begin
			short_cnt_reg <= short_cnt_reg + 1'b1;
		end
	end

	// trickle timer runs through trickle and short fault
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trk_cnt_reg <= '0;
		end else if (state_reg != ST_TRICKLE && state_reg != ST_FAULT) begin
			trk_cnt_reg <= '0;
		end else if (!trk_done) begin
			trk_cnt_reg <= trk_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// charger state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				state_next = ST_SINK;
			end
			ST_SINK: begin
				if (phase_done && !cmp[CMP_BAT_LOW]) begin
					state_next = ST_SOURCE;
				end else if (phase_done) begin
					state_next = cmp[CMP_BAT_DEAD] ? ST_FAST : ST_TRICKLE;
				end
			end
			ST_SOURCE: begin
				if (cmp[CMP_BAT_HIGH]) begin
					state_next = ST_NO_BAT;
				end else if (phase_done) begin
					state_next = ST_TRICKLE;
				end
			end
			ST_NO_BAT: begin
				// retry detection after one period
				if (phase_done) begin
					state_next = ST_SINK;
				end
			end
			ST_TRICKLE: begin
				if (short_done && !cmp[CMP_BAT_SHORT]) begin
					state_next = ST_FAULT;
				end else if (cmp[CMP_BAT_DEAD]) begin
					state_next = ST_FAST;
				end
			end
			ST_FAST: begin
				state_next = ST_FAST;
			end
			ST_FAULT: begin
				if (!short_fault_reg) begin
					state_next = ST_OFF;
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
		if (!cmp[CMP_SUPPLY_OK]) begin
			state_next = ST_OFF;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// short fault: set wins over software clear, supply loss clears
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			short_fault_reg <= 1'b0;
		end else if (state_next == ST_FAULT && state_reg == ST_TRICKLE) begin
			short_fault_reg <= 1'b1;
		end else if (!cmp[CMP_SUPPLY_OK]) begin
			short_fault_reg <= 1'b0;
		end else if (wr_fault && reg_wdata[FAULT_SHORT_BIT]) begin
			short_fault_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// thermistor gating and zones
	logic [CNT_W-1:0] therm_cnt_reg; // interval divider
	logic therm_tick; // one cycle per interval

	assign therm_tick = (therm_cnt_reg == THERM_CYCLES - 1'b1);

	// sensing allowed per supply and battery level
	always_comb begin
		if (cmp[CMP_SUPPLY_RANGE]) begin
			therm_active = 1'b1;
		end else if (cmp[CMP_BAT_CUTOFF]) begin
			therm_active = therm_en_reg;
		end else begin
			therm_active = 1'b0;
		end
	end

	// interval divider
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			therm_cnt_reg <= '0;
		end else if (!therm_active || therm_tick) begin
			therm_cnt_reg <= '0;
		end else begin
			therm_cnt_reg <= therm_cnt_reg + 1'b1;
		end
	end

	// zone decode; open input reads as cold
	always_comb begin
		if (!therm_active) begin
			zone = ZONE_TYP;
		end else if (cmp[CMP_COLD]) begin
			zone = ZONE_COLD;
		end else if (cmp[CMP_HOT]) begin
			zone = ZONE_HOT;
		end else if (cmp[CMP_WARM]) begin
			zone = ZONE_WARM;
		end else if (cmp[CMP_COOL]) begin
			zone = ZONE_COOL;
		end else begin
			zone = ZONE_TYP;
		end
	end

	assign temp_stop = (zone == ZONE_COLD) || (zone == ZONE_HOT);

	////////////////////////////////////////////////////////////////////
	// isolation switch mode
	iso_mode_type iso_next;

	always_comb begin
		if (!cmp[CMP_SUPPLY_OK]) begin
			iso_next = ISO_FULL;
		end else if (state_reg == ST_FAULT) begin
			iso_next = ISO_OFF;
		end else if (cmp[CMP_SYS_LOW]) begin
			iso_next = ISO_FULL;
		end else if (temp_stop) begin
			iso_next = ISO_FULL;
		end else if (state_reg == ST_TRICKLE) begin
			iso_next = ISO_OFF;
		end else if (cmp[CMP_BAT_SYS]) begin
			iso_next = ISO_FULL;
		end else if (cmp[CMP_BAT_DEAD]) begin
			iso_next = ISO_REGULATE;
		end else begin
			iso_next = ISO_OFF;
		end
	end

	////////////////////////////////////////////////////////////////////
	// charge settings per zone
	logic [4:0] cool_code; // reduced current
	logic [4:0] current_next;
	logic drop_next;

	cool_current_map cool_map (
		.code_in(current_reg),
		.code_out(cool_code)
	);

	// first profile cool halves current, warm or second cool drop voltage
	always_comb begin
		current_next = current_reg;
		drop_next = 1'b0;
		if (jeita_en_reg && zone == ZONE_COOL && !jeita_sel_reg) begin
			current_next = cool_code;
		end
		if (jeita_en_reg && zone == ZONE_COOL && jeita_sel_reg) begin
			drop_next = 1'b1;
		end
		if (jeita_en_reg && zone == ZONE_WARM) begin
			drop_next = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iso_mode <= ISO_FULL;
			sink_current_on <= 1'b0;
			source_current_on <= 1'b0;
			trickle_charge_on <= 1'b0;
			fast_charge_on <= 1'b0;
			charge_current_code <= CURRENT_RESET;
			termination_drop <= 1'b0;
			thermistor_source_on <= 1'b0;
		end else begin
			iso_mode <= iso_next;
			sink_current_on <= (state_reg == ST_SINK);
			source_current_on <= (state_reg == ST_SOURCE);
			trickle_charge_on <= !temp_stop &&
				((state_reg == ST_TRICKLE) ||
				(state_reg == ST_FAULT && !trk_done));
			fast_charge_on <= (state_reg == ST_FAST) && !temp_stop;
			charge_current_code <= current_next;
			termination_drop <= drop_next;
			thermistor_source_on <= therm_active &&
				(therm_cnt_reg < THERM_ON_CYCLES);
		end
	end

	// read data, one cycle after strobe, unmapped reads zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (reg_addr == CTRL_ADDR) begin
			reg_rdata <= DATA_W'({jeita_sel_reg, jeita_en_reg,
				therm_en_reg});
		end else if (reg_addr == CURRENT_ADDR) begin
			reg_rdata <= DATA_W'(current_reg);
		end else if (reg_addr == FAULT_ADDR) begin
			reg_rdata <= DATA_W'(short_fault_reg);
		end else if (reg_addr == STATUS_ADDR) begin
			reg_rdata <= DATA_W'({therm_active, zone, iso_mode,
				state_reg});
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking chk_clk @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	fault_exit_a: assert property (
		state_reg == ST_FAULT && !short_fault_reg |=> state_reg == ST_OFF)
		else $error("fault state not left after clear");
	fault_hold_a: assert property (
		state_reg == ST_FAULT && short_fault_reg && cmp[CMP_SUPPLY_OK]
		&& !(wr_fault && reg_wdata[FAULT_SHORT_BIT]) |=>
		state_reg == ST_FAULT)
		else $error("fault state left without clear");
	iso_supply_a: assert property (
		!cmp[CMP_SUPPLY_OK] |=> iso_mode == ISO_FULL)
		else $error("switch not full with low supply");
	iso_trickle_a: assert property (
		state_reg == ST_TRICKLE && cmp[CMP_SUPPLY_OK] && !temp_stop
		&& !cmp[CMP_SYS_LOW] |=> iso_mode == ISO_OFF)
		else $error("switch on during trickle");
	sink_decide_a: assert property (
		state_reg == ST_SINK && phase_done && !cmp[CMP_BAT_LOW]
		&& cmp[CMP_SUPPLY_OK] |=> state_reg == ST_SOURCE ##1
		source_current_on)
		else $error("sink phase did not start source phase");
	source_high_a: assert property (
		state_reg == ST_SOURCE && cmp[CMP_BAT_HIGH] && cmp[CMP_SUPPLY_OK]
		|=> state_reg == ST_NO_BAT)
		else $error("absent battery not flagged");
	short_fault_a: assert property (
		state_reg == ST_TRICKLE && short_done && !cmp[CMP_BAT_SHORT]
		&& cmp[CMP_SUPPLY_OK] |=> short_fault_reg and
		(cmp[CMP_SUPPLY_OK] |=> iso_mode == ISO_OFF))
		else $error("short not faulted");
	therm_gate_a: assert property (
		!cmp[CMP_SUPPLY_RANGE] && !cmp[CMP_BAT_CUTOFF]
		|=> !thermistor_source_on)
		else $error("thermistor source on while gated off");
	temp_stop_a: assert property (
		temp_stop |=> !fast_charge_on && !trickle_charge_on)
		else $error("charging during cold or hot");
	warm_drop_a: assert property (
		jeita_en_reg && zone == ZONE_WARM |=> termination_drop)
		else $error("warm zone kept full termination");
	cool_map_a: assert property (
		jeita_en_reg && !jeita_sel_reg && zone == ZONE_COOL
		|=> charge_current_code == $past(cool_code))
		else $error("cool zone current not reduced");
endmodule : charger_path_ctrl
`default_nettype wire

// [verification/battery_pack_model.sv]
// battery pack, thermistor and system load beside the path control
// assumes the bench sets voltages in mV and temperature in degrees C
`default_nettype none
module battery_pack_model
	import charger_path_pkg::*;
#(
	parameter int VIN_OK_MV = 3900,
	parameter int LOW_MV = 1000,
	parameter int HIGH_MV = 4000,
	parameter int SHORT_MV = 2000,
	parameter int DEAD_MV = 2600,
	parameter int SYS_MV = 3500,
	parameter int CUT_MV = 2500
) (
	// scene set by the bench
	input wire logic present,
	input wire logic [15:0] bat_mv,
	input wire logic [15:0] vin_mv,
	input wire logic signed [7:0] temp_c,
	input wire logic therm_open,
	input wire logic sys_sag,
	// currents from the block
	input wire logic sink_on,
	input wire logic source_on,
	// comparator levels
	output logic [CMP_W-1:0] cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	int node; // an empty node follows whatever current is forced in
	// comparator levels from the scene; an empty node idles at the low
	// detect level, is pulled to ground by the sink and up by the source
	always_comb begin
		node = present ? int'(bat_mv) :
			(source_on ? 5000 : (sink_on ? 0 : LOW_MV));
		cmp = '0;
		cmp[CMP_SUPPLY_OK] = int'(vin_mv) >= VIN_OK_MV;
		cmp[CMP_SUPPLY_RANGE] = vin_mv >= 16'd4000 && vin_mv <= 16'd6700;
		cmp[CMP_BAT_DEAD] = node > DEAD_MV;
		cmp[CMP_BAT_SYS] = node > SYS_MV;
		cmp[CMP_SYS_LOW] = sys_sag;
		cmp[CMP_BAT_LOW] = node > LOW_MV;
		cmp[CMP_BAT_HIGH] = node > HIGH_MV;
		cmp[CMP_BAT_SHORT] = node > SHORT_MV;
		cmp[CMP_BAT_CUTOFF] = node > CUT_MV;
		cmp[CMP_COLD] = therm_open || temp_c < 0;
		cmp[CMP_COOL] = !therm_open && temp_c >= 0 && temp_c < 10;
		cmp[CMP_WARM] = temp_c >= 45 && temp_c <= 60;
		cmp[CMP_HOT] = temp_c > 60;
	end
endmodule : battery_pack_model
`default_nettype wire

// [verification/charger_path_ctrl_tb_top.sv]
// self-checking bench for the battery path control
// assumes the pack model supplies every comparator level
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module charger_path_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import charger_path_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, present, therm_open, sys_sag;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_val, bat_mv, vin_mv;
	logic signed [7:0] temp_c;
	logic [CMP_W-1:0] cmp;
	logic [1:0] iso_mode;
	logic sink_on, src_on, trk_on, fast_on, drop, th_on, s_seen, c_seen;
	logic [4:0] code;
	int error_cnt, cmp_count, cycles, n;
	// expected cool zone codes, row index is the programmed code
	logic [4:0] cool_map [24] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5,
		5, 6, 6, 7, 7, 8, 8, 9, 9, 10, 11, 12};
	////////////////////////////////////////////////////////////////////
	charger_path_ctrl #(.DETECT_CYCLES(40'h00_0000_0008),
		.SHORT_CYCLES(40'h00_0000_0008), .TRICKLE_CYCLES(40'h00_0000_0040),
		.THERM_CYCLES(40'h00_0000_0020), .THERM_ON_CYCLES(40'h00_0000_0004)
	) u_charger_path_ctrl (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .supply_input_ok(cmp[CMP_SUPPLY_OK]),
		.supply_input_in_range(cmp[CMP_SUPPLY_RANGE]),
		.battery_above_dead(cmp[CMP_BAT_DEAD]),
		.battery_above_system_level(cmp[CMP_BAT_SYS]),
		.system_node_below_battery(cmp[CMP_SYS_LOW]),
		.battery_above_detect_low(cmp[CMP_BAT_LOW]),
		.battery_above_detect_high(cmp[CMP_BAT_HIGH]),
		.battery_above_short(cmp[CMP_BAT_SHORT]),
		.battery_above_cutoff(cmp[CMP_BAT_CUTOFF]),
		.thermistor_cold(cmp[CMP_COLD]), .thermistor_cool(cmp[CMP_COOL]),
		.thermistor_warm(cmp[CMP_WARM]), .thermistor_hot(cmp[CMP_HOT]),
		.iso_mode(iso_mode), .sink_current_on(sink_on),
		.source_current_on(src_on), .trickle_charge_on(trk_on),
		.fast_charge_on(fast_on), .charge_current_code(code),
		.termination_drop(drop), .thermistor_source_on(th_on));
	battery_pack_model u_battery_pack_model (.present(present),
		.bat_mv(bat_mv), .vin_mv(vin_mv), .temp_c(temp_c),
		.therm_open(therm_open), .sys_sag(sys_sag), .sink_on(sink_on),
		.source_on(src_on), .cmp(cmp));
	////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	// register port cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done
	task automatic complete_run;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0;
		reg_wdata = '0; present = 1'b1; bat_mv = 16'd3800; vin_mv = '0;
		temp_c = 8'sd25; therm_open = 1'b0; sys_sag = 1'b0;
		step(1);
		`CHK("iso in reset", ISO_FULL, iso_mode)
		@(posedge clk);
		rst_b <= 1'b1;
		rd(CTRL_ADDR);
		`CHK("ctrl reset", 16'h0000, rd_val)
		rd(CURRENT_ADDR);
		`CHK("current reset", 16'h0007, rd_val)
		rd(4'hF);
		`CHK("unmapped", 16'h0000, rd_val)
		`CHK("iso no supply", ISO_FULL, iso_mode)
		done("reset");
		// cool zone map rows, sensing enabled by software on battery
		wr(CTRL_ADDR, 16'h0003);
		temp_c <= 8'sd5;
		step(4);
		for (int i = 0; i < 24; i++) begin
			wr(CURRENT_ADDR, 16'(i));
			step(3);
			`CHK("cool code", cool_map[i], code)
		end
		rd(STATUS_ADDR);
		`CHK("sense on", 1'b1, rd_val[STAT_THERM_BIT])
		done("cool map");
		// second profile and other zones
		wr(CURRENT_ADDR, 16'h0010);
		wr(CTRL_ADDR, 16'h0007);
		step(4);
		`CHK("cool drop", 1'b1, drop)
		`CHK("cool code 2", 5'h10, code)
		temp_c <= 8'sd50;
		step(4);
		`CHK("warm drop", 1'b1, drop)
		temp_c <= 8'sd25;
		step(4);
		`CHK("typ drop", 1'b0, drop)
		`CHK("typ code", 5'h10, code)
		wr(CTRL_ADDR, 16'h0001);
		temp_c <= 8'sd5;
		step(4);
		`CHK("off code", 5'h10, code)
		bat_mv <= 16'd2000;
		step(4);
		rd(STATUS_ADDR);
		`CHK("sense cut", 1'b0, rd_val[STAT_THERM_BIT])
		bat_mv <= 16'd3800;
		wr(CTRL_ADDR, 16'h0000);
		n = 0;
		repeat (40) begin step(1); n += int'(th_on); end
		`CHK("source idle", 0, n)
		done("zones");
		// present battery, sink then trickle then fast
		temp_c <= 8'sd25;
		bat_mv <= 16'd2200;
		vin_mv <= 16'd5000;
		while (sink_on !== 1'b1) step(1);
		n = 0;
		while (sink_on === 1'b1) begin step(1); n++; end
		`CHK("sink len", 8, n)
		step(3);
		`CHK("trickle", 1'b1, trk_on)
		`CHK("iso trickle", ISO_OFF, iso_mode)
		n = 0;
		repeat (64) begin step(1); n += int'(th_on); end
		`CHK("therm pulses", 8, n)
		bat_mv <= 16'd3000;
		step(6);
		`CHK("fast", 1'b1, fast_on)
		`CHK("iso reg", ISO_REGULATE, iso_mode)
		sys_sag <= 1'b1;
		step(5);
		`CHK("iso sag", ISO_FULL, iso_mode)
		sys_sag <= 1'b0;
		step(5);
		`CHK("iso back", ISO_REGULATE, iso_mode)
		bat_mv <= 16'd3800;
		step(5);
		`CHK("iso full", ISO_FULL, iso_mode)
		bat_mv <= 16'd3000;
		temp_c <= 8'sd65;
		step(5);
		`CHK("hot stop", 1'b0, fast_on)
		`CHK("hot iso", ISO_FULL, iso_mode)
		temp_c <= 8'sd25;
		therm_open <= 1'b1;
		step(5);
		`CHK("open stop", 1'b0, fast_on)
		therm_open <= 1'b0;
		vin_mv <= 16'd0;
		step(5);
		`CHK("iso unplug", ISO_FULL, iso_mode)
		done("charge");
		// absent battery, sink then source then no battery
		present <= 1'b0;
		vin_mv <= 16'd5000;
		s_seen = 1'b0;
		c_seen = 1'b0;
		repeat (60) begin
			step(1);
			s_seen |= src_on;
			c_seen |= trk_on | fast_on;
		end
		`CHK("source seen", 1'b1, s_seen)
		`CHK("no charge", 1'b0, c_seen)
		vin_mv <= 16'd0;
		step(5);
		done("absent");
		// shorted battery: trickle, fault, clear
		present <= 1'b1;
		bat_mv <= 16'd500;
		vin_mv <= 16'd5000;
		while (trk_on !== 1'b1) step(1);
		step(12);
		`CHK("short iso", ISO_OFF, iso_mode)
		rd(FAULT_ADDR);
		`CHK("fault bit", 1'b1, rd_val[FAULT_SHORT_BIT])
		`CHK("trk in fault", 1'b1, trk_on)
		step(70);
		`CHK("trk expired", 1'b0, trk_on)
		rd(STATUS_ADDR);
		`CHK("held fault", ST_FAULT, rd_val[2:0])
		wr(FAULT_ADDR, 16'h0001);
		rd(STATUS_ADDR);
		`CHK("fault left", 1'b1, rd_val[2:0] !== ST_FAULT)
		done("short");
		complete_run();
	end
endmodule : charger_path_ctrl_tb_top
`default_nettype wire
